/* inc/reply_pkg.sv */
// Package with reply packet constants and carrier types.
package reply_pkg;
  localparam logic [7:0] START_BYTE = 8'h5a;
  localparam logic [7:0] FRAMED_COMMAND_TYPE = 8'ha4;
  localparam logic [7:0] TAG_STATUS = 8'ha0;
  localparam logic [7:0] TAG_PROPERTY = 8'ha7;
  localparam logic [7:0] TAG_MEMORY_READ = 8'ha3;
  localparam logic [7:0] TAG_OTP_READ = 8'haf;
  localparam logic [7:0] TAG_RESOURCE_READ = 8'hb0;
  localparam logic [7:0] FLAGS_NONE = 8'h00;
  localparam logic [7:0] DATA_PHASE_FLAG = 8'h01;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  localparam logic [31:0] SUCCESS_CODE = 32'h00000000;
  localparam logic [31:0] MEM_INTERNAL_FLASH = 32'h00000000;
  localparam logic [31:0] MEM_SERIAL_EXTERNAL = 32'h00000001;
  localparam logic [3:0] STATUS_PARAMS = 4'h2;
  localparam logic [3:0] MAX_PARAMS = 4'h7;
  localparam logic [3:0] MAX_PROPERTY_VALUES = 4'h6;
  localparam logic [3:0] MAX_OTP_WORDS = 4'h5;
  localparam logic [7:0] HEADER_BYTES = 8'h04;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  typedef enum logic [2:0] {
    KIND_STATUS = 3'h0,
    KIND_PROPERTY = 3'h1,
    KIND_MEMORY_READ = 3'h2,
    KIND_OTP_READ = 3'h3,
    KIND_RESOURCE_READ = 3'h4
  } reply_kind_e;

  typedef struct packed {
    reply_kind_e kind;
    logic [7:0] command_tag;
    logic [31:0] status;
    logic [31:0] byte_count;
    logic [3:0] value_count;
    logic [6:0][31:0] values;
  } reply_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } out_byte_s;
endpackage

/* hw/byte_skid.sv */
// Two-entry buffer carrying output bytes with valid and ready on both sides.
`timescale 1ns/1ps
module byte_skid #(
  parameter int WIDTH = 9
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0] count;
  logic push;
  logic pop;

  // A zero-width carrier cannot hold a byte and its marker.
  if (WIDTH < 1) begin : g_width_check
    $error("byte_skid width must be positive");
  end

  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 2'd0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Slot0 always holds the oldest word, so the output stays a register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slot0 <= '0;
      slot1 <= '0;
    end else begin
      if (pop) begin
        slot0 <= (count == 2'd2) ? slot1 : in_data;
        if (push && count == 2'd2) begin
          slot1 <= in_data;
        end
      end else if (push) begin
        if (count == 2'd0) begin
          slot0 <= in_data;
        end else begin
          slot1 <= in_data;
        end
      end
    end
  end
endmodule

/* hw/target_response_packet_builder.sv */
// Builder that serialises framed reply packets byte by byte.
`timescale 1ns/1ps
module target_response_packet_builder (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire reply_pkg::reply_req_s req,
  input wire logic req_valid,
  output logic req_ready,
  output logic req_error,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HEAD = 3'b001,
    ST_CRC = 3'b011,
    ST_CRC_OUT = 3'b010,
    ST_BODY = 3'b110
  } state_e;

  state_e state;
  logic [7:0] pkt [0:31];
  logic [5:0] pkt_len;
  logic [5:0] idx;
  logic [15:0] crc;
  logic [2:0] frame_idx;
  logic [7:0] next_byte;
  logic next_last;
  logic emit;
  logic buf_ready;
  logic [15:0] next_crc;
  logic req_ok;
  logic [7:0] hdr_tag;
  logic [7:0] hdr_flags;
  logic [3:0] hdr_count;
  logic [6:0][31:0] params;
  reply_pkg::out_byte_s buf_in;
  reply_pkg::out_byte_s buf_out;

  // Build header fields and parameter list for the requested kind.
  always_comb begin
    hdr_tag = reply_pkg::TAG_STATUS;
    hdr_flags = reply_pkg::FLAGS_NONE;
    hdr_count = reply_pkg::STATUS_PARAMS;
    params = req.values;
    params[0] = req.status;
    req_ok = 1'b1;
    unique case (req.kind)
      reply_pkg::KIND_STATUS: begin
        hdr_tag = reply_pkg::TAG_STATUS;
        params[1] = {24'h000000, req.command_tag};
      end
      reply_pkg::KIND_PROPERTY: begin
        hdr_tag = reply_pkg::TAG_PROPERTY;
        hdr_flags = reply_pkg::FLAGS_NONE;
        hdr_count = req.value_count + 4'h1;
        params[6:1] = req.values[5:0];
        req_ok = (req.value_count != 4'h0) && (req.value_count <= reply_pkg::MAX_PROPERTY_VALUES);
      end
      reply_pkg::KIND_MEMORY_READ: begin
        hdr_tag = reply_pkg::TAG_MEMORY_READ;
        hdr_flags = reply_pkg::DATA_PHASE_FLAG;
        params[1] = req.byte_count;
      end
      reply_pkg::KIND_OTP_READ: begin
        hdr_tag = reply_pkg::TAG_OTP_READ;
        hdr_count = reply_pkg::STATUS_PARAMS + req.value_count;
        params[1] = req.byte_count;
        params[6:2] = req.values[4:0];
        req_ok = (req.value_count <= reply_pkg::MAX_OTP_WORDS);
      end
      reply_pkg::KIND_RESOURCE_READ: begin
        hdr_tag = reply_pkg::TAG_RESOURCE_READ;
        hdr_flags = reply_pkg::DATA_PHASE_FLAG;
        params[1] = req.byte_count;
      end
      default: begin
        req_ok = 1'b0;
      end
    endcase
  end

  assign req_ready = (state == ST_IDLE);

  // Bad requests are dropped; the pulse tells the caller nothing was sent.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_error <= 1'b0;
    end else begin
      req_error <= req_valid && req_ready && !req_ok;
    end
  end

  // Capture the command packet: header then parameters, low byte first.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pkt_len <= 6'd0;
      for (int i = 0; i < 32; i++) begin
        pkt[i] <= 8'h00;
      end
    end else if (req_valid && req_ready && req_ok) begin
      pkt[0] <= hdr_tag;
      pkt[1] <= hdr_flags;
      pkt[2] <= reply_pkg::RESERVED_BYTE;
      pkt[3] <= {4'h0, hdr_count};
      for (int p = 0; p < 7; p++) begin
        for (int b = 0; b < 4; b++) begin
          pkt[4 + p * 4 + b] <= params[p][b * 8 +: 8];
        end
      end
      pkt_len <= 6'(reply_pkg::HEADER_BYTES) + {hdr_count[3:0], 2'b00};
    end
  end

  // CRC update for one byte, MSB first without reflection.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ reply_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Byte selection per state; frame header is start, type, length low, length high.
  always_comb begin
    next_byte = 8'h00;
    next_last = 1'b0;
    emit = 1'b0;
    unique case (state)
      ST_IDLE: begin
        emit = 1'b0;
      end
      ST_HEAD: begin
        emit = 1'b1;
        unique case (frame_idx[1:0])
          2'd0: next_byte = reply_pkg::START_BYTE;
          2'd1: next_byte = reply_pkg::FRAMED_COMMAND_TYPE;
          2'd2: next_byte = {2'b00, pkt_len};
          2'd3: next_byte = 8'h00;
        endcase
      end
      ST_CRC: begin
        emit = 1'b0;
      end
      ST_CRC_OUT: begin
        emit = 1'b1;
        next_byte = frame_idx[0] ? crc[15:8] : crc[7:0];
      end
      ST_BODY: begin
        emit = 1'b1;
        next_byte = pkt[idx[4:0]];
        next_last = (idx == pkt_len - 6'd1);
      end
      default: begin
        emit = 1'b0;
      end
    endcase
  end

  // CRC is computed before transmission since its field precedes the payload.
  always_comb begin
    next_crc = crc;
    if (state == ST_HEAD && emit && buf_ready) begin
      next_crc = crc_step(crc, next_byte);
    end else if (state == ST_CRC) begin
      next_crc = crc_step(crc, pkt[idx[4:0]]);
    end
  end

  // Sequencer; each packet is self-contained so the caller orders status last.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      idx <= 6'd0;
      frame_idx <= 3'd0;
      crc <= reply_pkg::CRC_INIT;
    end else begin
      crc <= next_crc;
      unique case (state)
        ST_IDLE: begin
          if (req_valid && req_ok) begin
            state <= ST_HEAD;
            frame_idx <= 3'd0;
            crc <= reply_pkg::CRC_INIT;
          end
        end
        ST_HEAD: begin
          if (buf_ready) begin
            if (frame_idx == 3'd3) begin
              state <= ST_CRC;
              idx <= 6'd0;
            end else begin
              frame_idx <= frame_idx + 3'd1;
            end
          end
        end
        ST_CRC: begin
          if (idx == pkt_len - 6'd1) begin
            state <= ST_CRC_OUT;
            frame_idx <= 3'd0;
            idx <= 6'd0;
          end else begin
            idx <= idx + 6'd1;
          end
        end
        ST_CRC_OUT: begin
          if (buf_ready) begin
            if (frame_idx[0]) begin
              state <= ST_BODY;
            end
            frame_idx <= frame_idx + 3'd1;
          end
        end
        ST_BODY: begin
          if (buf_ready) begin
            if (next_last) begin
              state <= ST_IDLE;
            end else begin
              idx <= idx + 6'd1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign buf_in = '{data: next_byte, last: next_last};

  // The buffer absorbs receiver stalls so no byte is dropped mid-packet.
  byte_skid #(
    .WIDTH(9)
  ) out_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_data(buf_in),
    .in_valid(emit),
    .in_ready(buf_ready),
    .out_data(buf_out),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  assign tx_data = buf_out.data;
  assign tx_last = buf_out.last;
endmodule

/* verif/tx_sink.sv */
// Byte sink that stands in for the host receiving reply packets.
`timescale 1ns/1ps
module tx_sink (
  input wire logic sys_clk,
  input wire logic slow,
  output logic tx_ready
);
  int seed = 32'h5a17c3e1;
  initial tx_ready = 1'b0;
  // A slow host takes one byte in four, so the two-entry buffer must hold its words.
  always @(negedge sys_clk) begin
    tx_ready <= slow ? (($random(seed) & 3) == 0) : 1'b1;
  end
endmodule

/* verif/reply_builder_asserts.sv */
// Checker for the reply packet builder ports.
`timescale 1ns/1ps
module reply_builder_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire reply_pkg::reply_req_s req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_error,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  logic take;
  logic [5:0] idx;
  logic [7:0] tag;
  logic [7:0] len;
  assign acc = tx_valid && tx_ready;
  assign take = req_valid && req_ready;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      idx <= 6'h00;
      tag <= 8'h00;
      len <= 8'h00;
    end else if (acc) begin
      idx <= tx_last ? 6'h00 : idx + 6'h01;
      tag <= (idx == 6'h06) ? tx_data : tag;
      len <= (idx == 6'h02) ? tx_data : len;
    end
  end
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_start;
    acc && idx == 6'h00 |-> tx_data == 8'h5a;
  endproperty
  a_start: assert property (p_start) else $error("bad start byte");
  property p_type;
    acc && idx == 6'h01 |-> tx_data == reply_pkg::FRAMED_COMMAND_TYPE;
  endproperty
  a_type: assert property (p_type) else $error("bad packet type");
  property p_len;
    acc && tx_last |-> {2'b00, idx} == len + 8'h05;
  endproperty
  a_len: assert property (p_len) else $error("length field disagrees with bytes");
  property p_rsvd;
    acc && (idx == 6'h03 || idx == 6'h08) |-> tx_data == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
  property p_flags;
    acc && idx == 6'h07 |-> tx_data == ((tag == 8'ha3 || tag == 8'hb0) ? 8'h01 : 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("bad flags byte");
  property p_count;
    acc && idx == 6'h09 && tag == 8'ha0 |-> tx_data == 8'h02;
  endproperty
  a_count: assert property (p_count) else $error("status reply count not two");
  property p_refuse;
    take && req.kind == reply_pkg::KIND_PROPERTY && (req.value_count == 4'h0 || req.value_count > 4'h6)
      |=> req_error && req_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad value count taken");
  property p_otp;
    take && req.kind == reply_pkg::KIND_OTP_READ && req.value_count > 4'h5 |=> req_error;
  endproperty
  a_otp: assert property (p_otp) else $error("oversize read taken");
  c_status: cover property (acc && tx_last && tag == 8'ha0);
  c_error: cover property (req_error);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule
bind target_response_packet_builder reply_builder_asserts chk_u (.sys_clk(sys_clk), .resetn(resetn), .req(req),
  .req_valid(req_valid), .req_ready(req_ready), .req_error(req_error), .tx_data(tx_data), .tx_last(tx_last),
  .tx_valid(tx_valid), .tx_ready(tx_ready));

/* verif/tb_top.sv */
// Self-checking bench for the reply packet builder.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  reply_pkg::reply_req_s req = '0;
  logic req_valid = 1'b0;
  logic slow = 1'b0;
  logic req_ready, req_error, tx_last, tx_valid, tx_ready;
  logic [7:0] tx_data;
  int seed = 32'h1bf14c01;
  int fail_count = 0;
  int n_compared = 0;
  logic [8:0] expq[$];
  logic [7:0] tags[5] = '{8'ha0, 8'ha7, 8'ha3, 8'haf, 8'hb0};
  always #12.5 sys_clk = ~sys_clk;
  target_response_packet_builder dut_u (.sys_clk(sys_clk), .resetn(resetn), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .req_error(req_error), .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  tx_sink sink_u (.sys_clk(sys_clk), .slow(slow), .tx_ready(tx_ready));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) r = r[15] ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
    return r;
  endfunction
  task automatic send(input reply_pkg::reply_req_s r, input logic ok);
    logic [7:0] pl[$];
    logic [7:0] f[$];
    logic [31:0] w[$];
    logic [15:0] c;
    logic dp;
    dp = r.kind inside {reply_pkg::KIND_MEMORY_READ, reply_pkg::KIND_RESOURCE_READ};
    w.push_back(r.status);
    if (r.kind == reply_pkg::KIND_STATUS) w.push_back({24'h000000, r.command_tag});
    else if (r.kind != reply_pkg::KIND_PROPERTY) w.push_back(r.byte_count);
    if (r.kind inside {reply_pkg::KIND_PROPERTY, reply_pkg::KIND_OTP_READ}) begin
      for (int i = 0; i < r.value_count; i++) w.push_back(r.values[i]);
    end
    pl = {tags[r.kind], dp ? 8'h01 : 8'h00, 8'h00, 8'(w.size())};
    foreach (w[i]) for (int k = 0; k < 4; k++) pl.push_back(w[i][8*k +: 8]);
    f = {8'h5a, 8'ha4, 8'(pl.size()), 8'h00};
    c = 16'h0000;
    foreach (f[i]) c = crc_step(c, f[i]);
    foreach (pl[i]) c = crc_step(c, pl[i]);
    f = {f, c[7:0], c[15:8], pl};
    if (ok) foreach (f[i]) expq.push_back({f[i], i == f.size() - 1});
    // Let one edge pass so the valid strobe is never lowered and raised in one step.
    @(negedge sys_clk);
    while (req_ready !== 1'b1) @(negedge sys_clk);
    req = r;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    check({7'h00, req_ready, req_error}, {7'h00, !ok, !ok});
  endtask
  always @(posedge sys_clk) begin
    if (resetn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (expq.size() == 0) check({tx_data, tx_last}, 9'h1ff);
      else check({tx_data, tx_last}, expq.pop_front());
    end
  end
  initial begin
    reply_pkg::reply_req_s r;
    logic ok;
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    r = '0;
    r.command_tag = 8'h07;
    send(r, 1'b1);
    $display("status reply test done");
    for (int k = 0; k < 8; k++) begin
      for (int n = 0; n < 8; n++) begin
        r.status = $random(seed);
        r.byte_count = $random(seed);
        r.command_tag = 8'($random(seed));
        for (int i = 0; i < 7; i++) r.values[i] = $random(seed);
        r.kind = reply_pkg::reply_kind_e'(3'(k));
        r.value_count = 4'(n);
        slow = n[0];
        ok = (k == 0 || k == 2 || k == 4) || (k == 1 && n > 0 && n < 7) || (k == 3 && n < 6);
        send(r, ok);
      end
      $display("kind %0d test done", k);
    end
    // Let the slow sink drain everything before judging.
    for (int i = 0; i < 4000 && expq.size() != 0; i++) @(negedge sys_clk);
    check({8'h00, expq.size() == 0}, 9'h001);
    conclude();
  end
  initial begin
    #1000000;
    fail_count++;
    conclude();
  end
endmodule
